// ### hdl/dram_ctrl.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "dram_ctrl_regs.svh"

// How it works
// - accepted request command and address latched in holding registers
// - bank taken from address low bits, then column, then row
// - next-address request within latency window merges into same burst
// - long bursts split into single requests at consecutive addresses
// - write data pushed into fifo, popped only on phy demand
// - fsm waits in init until calibration passes
// - calibration failure sends fsm to init-failed
// - commands reach phy only in init-done
// - refresh wins over a same-cycle read or write
// - read or write waits for no pending refresh, then issues
// - timer raises periodic refresh when automatic refresh is on
// - data-bus timer spaces read and write commands
// - eight bank timers enforce row cycle time
// - eight-bit bank ready vector feeds the fsm
// - one parity bit added per write byte when enabled
// - read bytes checked, error output on mismatch
// - with parity, user width is eight per nine memory bits
// - user refresh mode disables the automatic timer
// - half rate rejects burst length two
// - parity and user refresh both off by default
// - HALF_RATE only gates the burst-two rejection; phy-facing timing is the same either way
module dram_ctrl #(
	parameter int  BYTES            = 2,
	parameter int  BURST_LEN        = 4,
	parameter bit  HALF_RATE        = 1'b0,
	parameter int  FIFO_DEPTH       = 8,
	parameter int  REFRESH_CYCLES   = `REFRESH_INTERVAL_NS / `CLK_PERIOD_NS,
	parameter int  MERGE_WINDOW     = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	// apb
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// user burst slave
	input  wire logic             user_read_req,
	input  wire logic             user_write_req,
	input  wire logic [24:0]      user_addr,
	input  wire logic [7:0]       user_size,
	input  wire logic [BYTES*8-1:0] user_wdata,
	output logic                  user_ready,
	output logic                  user_rdata_valid,
	output logic      [BYTES*8-1:0] user_rdata,
	output logic                  parity_error,
	// phy
	input  wire logic             cal_success,
	input  wire logic             cal_fail,
	input  wire logic             phy_wdata_req,
	input  wire logic             phy_rdata_valid,
	input  wire logic [BYTES*9-1:0] phy_rdata,
	output dram_ctrl_pkg::phy_cmd_s phy_cmd,
	output logic      [BYTES*9-1:0] phy_wdata,
	output logic                  phy_wdata_valid
);
	localparam int RC_CYCLES = (`BANK_ROW_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int DQ_CYCLES = (`DATA_BUS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int DW = BYTES * 8;
	localparam int MW = BYTES * 9;

	// half rate with burst of two parks in init-failed, so it never issues
	localparam bit REJECT_BL2 = HALF_RATE && (BURST_LEN == 2);

	function automatic logic [MW-1:0] add_parity(input logic [DW-1:0] d, input logic en);
		logic [MW-1:0] r;
		r = '0;
		for (int b = 0; b < BYTES; b++)
			r[b*9 +: 9] = {en ? ^d[b*8 +: 8] : 1'b0, d[b*8 +: 8]};
		return r;
	endfunction

	function automatic logic parity_bad(input logic [MW-1:0] d);
		logic bad;
		bad = 1'b0;
		for (int b = 0; b < BYTES; b++)
			bad = bad | (^d[b*9 +: 9]);
		return bad;
	endfunction

	// =====================================================================
	// apb registers
	logic [31:0] ctrl_r;
	logic        user_refresh_pulse_r;
	logic [15:0] err_count_r;

	wire apb_setup  = psel && !penable;
	wire apb_access = psel && penable;
	wire apb_wr     = apb_access && pwrite;
	wire ctrl_hit   = paddr == `CTRL_ADDR;
	wire status_hit = paddr == `STATUS_ADDR;
	wire refr_hit   = paddr == `REFRESH_REQ_ADDR;
	wire errc_hit   = paddr == `ERROR_COUNT_ADDR;
	wire addr_ok    = ctrl_hit || status_hit || refr_hit || errc_hit;
	wire user_refresh_mode = ctrl_r[`CTRL_USER_REFRESH_BIT];
	wire parity_en         = ctrl_r[`CTRL_PARITY_EN_BIT];

	dram_ctrl_pkg::cmd_state_e state_r;
	logic [7:0]                bank_ready;
	logic                      sticky_err_r;

	wire [31:0] status_word = {15'h0000, sticky_err_r, bank_ready, 6'h00, state_r};
	wire [31:0] rd_mux = ctrl_hit ? ctrl_r :
	                     status_hit ? status_word :
	                     errc_hit ? {16'h0000, err_count_r} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r               <= `CTRL_RESET_VALUE;
			user_refresh_pulse_r <= 1'b0;
			prdata               <= 32'h00000000;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
		end else begin
			pready               <= apb_setup;
			pslverr              <= apb_setup && !addr_ok;
			user_refresh_pulse_r <= apb_wr && pready && refr_hit && pwdata[0] && user_refresh_mode;
			if (apb_setup)
				prdata <= rd_mux;
			if (apb_wr && pready && ctrl_hit)
				ctrl_r <= {30'h00000000, pwdata[1:0]};
		end
	end

	// =====================================================================
	// burst divider and holding registers
	logic [24:0] hold_addr_r;
	logic [7:0]  beats_left_r;
	logic        hold_rd_r;
	logic        hold_wr_r;
	logic        fifo_full;
	logic        fifo_empty;
	logic        issue_rw;

	wire hold_busy = beats_left_r != 8'h00;
	wire accept    = user_ready && (user_read_req || user_write_req);
	wire wbeat     = user_ready && user_write_req;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_addr_r  <= 25'h0000000;
			beats_left_r <= 8'h00;
			hold_rd_r    <= 1'b0;
			hold_wr_r    <= 1'b0;
			user_ready   <= 1'b0;
		end else begin
			if (accept && !hold_busy) begin
				hold_addr_r  <= user_addr;
				beats_left_r <= (user_size == 8'h00) ? 8'h01 : user_size;
				hold_rd_r    <= user_read_req;
				hold_wr_r    <= user_write_req;
			end else if (issue_rw) begin
				hold_addr_r  <= hold_addr_r + 25'h0000001;
				beats_left_r <= beats_left_r - 8'h01;
			end
			// accept only with an empty holder and fifo room
			user_ready <= (state_r == dram_ctrl_pkg::ST_INIT_DONE) && !fifo_full && !hold_busy && !accept;
		end
	end

	// bank in low bits, column next, row above
	wire [2:0]  req_bank = hold_addr_r[2:0];
	wire [5:0]  req_col  = hold_addr_r[8:3];
	wire [15:0] req_row  = hold_addr_r[24:9];

	// =====================================================================
	// write data fifo
	logic [MW-1:0] fifo_q;
	logic          fifo_pop;

	assign fifo_pop = phy_wdata_req && !fifo_empty;
	// fifo read data is already a flop: the word lands with phy_wdata_valid
	assign phy_wdata = fifo_q;

	wdata_fifo #(
		.WIDTH(MW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk     (pclk),
		.presetn  (presetn),
		.push     (wbeat),
		.push_data(add_parity(user_wdata, parity_en)),
		.pop      (fifo_pop),
		.pop_data (fifo_q),
		.full     (fifo_full),
		.empty    (fifo_empty)
	);

	// =====================================================================
	// refresh timer
	logic [15:0] refresh_cnt_r;
	logic        refresh_pend_r;
	logic        issue_refresh;

	wire refresh_tick = !user_refresh_mode && refresh_cnt_r == 16'(REFRESH_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_cnt_r  <= 16'h0000;
			refresh_pend_r <= 1'b0;
		end else begin
			if (user_refresh_mode || refresh_tick)
				refresh_cnt_r <= 16'h0000;
			else
				refresh_cnt_r <= refresh_cnt_r + 16'h0001;
			if (refresh_tick || user_refresh_pulse_r)
				refresh_pend_r <= 1'b1; // set wins over clear
			else if (issue_refresh)
				refresh_pend_r <= 1'b0;
		end
	end

	// =====================================================================
	// timers
	logic dq_ready;

	bank_timers #(
		.BANKS    (8),
		.RC_CYCLES(RC_CYCLES),
		.DQ_CYCLES(DQ_CYCLES)
	) u_timers (
		.pclk      (pclk),
		.presetn   (presetn),
		.issue     (issue_rw || issue_refresh),
		.issue_bank(issue_refresh ? 3'h0 : req_bank),
		.issue_data(issue_rw),
		.bank_ready(bank_ready),
		.dq_ready  (dq_ready)
	);

	// =====================================================================
	// command fsm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_r <= dram_ctrl_pkg::ST_INIT;
		else begin
			case (state_r)
				dram_ctrl_pkg::ST_INIT: begin
					if (cal_fail || REJECT_BL2)
						state_r <= dram_ctrl_pkg::ST_INIT_FAIL;
					else if (cal_success)
						state_r <= dram_ctrl_pkg::ST_INIT_DONE;
				end
				dram_ctrl_pkg::ST_INIT_DONE: ;
				dram_ctrl_pkg::ST_INIT_FAIL: ;
				default: state_r <= dram_ctrl_pkg::ST_INIT;
			endcase
		end
	end

	wire run = state_r == dram_ctrl_pkg::ST_INIT_DONE;
	// refresh first; read or write once none pending and timers allow
	assign issue_refresh = run && refresh_pend_r && bank_ready[0];
	assign issue_rw      = run && !refresh_pend_r && hold_busy && bank_ready[req_bank] && dq_ready;

	// consecutive address in the open burst window merges, no new command
	logic [24:0] last_addr_r;
	logic [3:0]  window_r;
	logic        last_rd_r;
	logic [1:0]  merge_beats_r;
	wire         merge = window_r != 4'h0 && hold_addr_r == last_addr_r + 25'h0000001
	                     && last_rd_r == hold_rd_r && merge_beats_r < 2'(BURST_LEN / 2 - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_cmd       <= '0;
			last_addr_r   <= 25'h0000000;
			window_r      <= 4'h0;
			last_rd_r     <= 1'b0;
			merge_beats_r <= 2'h0;
		end else begin
			phy_cmd.cmd <= dram_ctrl_pkg::CMD_NOP;
			if (window_r != 4'h0)
				window_r <= window_r - 4'h1;
			if (issue_refresh) begin
				phy_cmd.cmd  <= dram_ctrl_pkg::CMD_REFRESH;
				phy_cmd.bank <= 3'h0;
				window_r     <= 4'h0;
			end else if (issue_rw) begin
				last_addr_r <= hold_addr_r;
				last_rd_r   <= hold_rd_r;
				if (merge) begin
					merge_beats_r <= merge_beats_r + 2'h1;
				end else begin
					phy_cmd.cmd   <= hold_rd_r ? dram_ctrl_pkg::CMD_READ : dram_ctrl_pkg::CMD_WRITE;
					phy_cmd.bank  <= req_bank;
					phy_cmd.row   <= req_row;
					phy_cmd.col   <= req_col;
					merge_beats_r <= 2'h0;
					window_r      <= 4'(MERGE_WINDOW);
				end
				phy_cmd.beats <= merge ? merge_beats_r + 2'h1 : 2'h0;
			end
		end
	end

	// =====================================================================
	// write data to phy, read data back with parity check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_wdata_valid  <= 1'b0;
			user_rdata_valid <= 1'b0;
			user_rdata       <= '0;
			parity_error     <= 1'b0;
			sticky_err_r     <= 1'b0;
			err_count_r      <= 16'h0000;
		end else begin
			phy_wdata_valid  <= fifo_pop;
			user_rdata_valid <= phy_rdata_valid;
			parity_error     <= phy_rdata_valid && parity_en && parity_bad(phy_rdata);
			for (int b = 0; b < BYTES; b++)
				user_rdata[b*8 +: 8] <= phy_rdata[b*9 +: 8];
			if (phy_rdata_valid && parity_en && parity_bad(phy_rdata)) begin
				sticky_err_r <= 1'b1;
				err_count_r  <= err_count_r + 16'h0001;
			end else if (apb_wr && pready && status_hit && pwdata[`STATUS_PARITY_ERR_BIT])
				sticky_err_r <= 1'b0;
		end
	end

	// =====================================================================
	// checks
	sequence s_user_accept;
		user_ready && (user_read_req || user_write_req);
	endsequence
	a_cmd_only_done: assert property (@(posedge pclk) disable iff (!presetn)
		phy_cmd.cmd != dram_ctrl_pkg::CMD_NOP |-> $past(state_r) == dram_ctrl_pkg::ST_INIT_DONE)
		else $error("command outside init done");
	a_fail_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == dram_ctrl_pkg::ST_INIT && cal_fail |=> state_r == dram_ctrl_pkg::ST_INIT_FAIL [*3])
		else $error("calibration fail not held");
	a_cal_pass: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == dram_ctrl_pkg::ST_INIT && cal_success && !cal_fail && !REJECT_BL2
		|=> state_r == dram_ctrl_pkg::ST_INIT_DONE)
		else $error("calibration pass ignored");
	a_refresh_first: assert property (@(posedge pclk) disable iff (!presetn)
		run && refresh_pend_r && bank_ready[0] |=> phy_cmd.cmd == dram_ctrl_pkg::CMD_REFRESH)
		else $error("read or write ahead of refresh");
	a_bank_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		RC_CYCLES > 1 && issue_rw |=> !bank_ready[$past(req_bank)])
		else $error("bank row cycle violated");
	a_auto_refresh: assert property (@(posedge pclk) disable iff (!presetn)
		refresh_tick |=> refresh_pend_r)
		else $error("refresh tick lost");
	a_user_mode_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		user_refresh_mode |=> refresh_cnt_r == 16'h0000)
		else $error("auto refresh timer runs in user mode");
	a_parity_flag: assert property (@(posedge pclk) disable iff (!presetn)
		phy_rdata_valid && parity_en && parity_bad(phy_rdata) |=> parity_error && user_rdata_valid)
		else $error("parity mismatch not flagged");
	a_wdata_pop: assert property (@(posedge pclk) disable iff (!presetn)
		phy_wdata_valid |-> $past(phy_wdata_req))
		else $error("write data without demand");
	a_accept_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		s_user_accept |=> !user_ready)
		else $error("ready held after accept");
endmodule // dram_ctrl

// ### hdl/dram_ctrl_regs.svh
`ifndef DRAM_CTRL_REGS_SVH
`define DRAM_CTRL_REGS_SVH

// apb register byte addresses
`define CTRL_ADDR        12'h000
`define STATUS_ADDR      12'h004
`define REFRESH_REQ_ADDR 12'h008
`define ERROR_COUNT_ADDR 12'h00C

// control field positions
`define CTRL_USER_REFRESH_BIT 0
`define CTRL_PARITY_EN_BIT    1
`define CTRL_RESET_VALUE      32'h00000000

// status field positions
`define STATUS_FSM_LSB        0
`define STATUS_BANK_READY_LSB 8
`define STATUS_PARITY_ERR_BIT 16

// timing in ns, converted to 100 MHz cycles in the design
`define CLK_PERIOD_NS         10
`define BANK_ROW_CYCLE_NS     20
`define DATA_BUS_GAP_NS       20
`define REFRESH_INTERVAL_NS   3900

`endif

// ### hdl/dram_ctrl_pkg.sv
package dram_ctrl_pkg;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_INIT_DONE,
		ST_INIT_FAIL
	} cmd_state_e;

	typedef enum logic [1:0] {
		CMD_NOP,
		CMD_READ,
		CMD_WRITE,
		CMD_REFRESH
	} mem_cmd_e;

	typedef struct packed {
		mem_cmd_e    cmd;
		logic [2:0]  bank;
		logic [15:0] row;
		logic [5:0]  col;
		logic [1:0]  beats;
	} phy_cmd_s;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [24:0] addr;
	} user_req_s;

endpackage

// ### hdl/wdata_fifo.sv
`timescale 1ns/1ps

// =====================================================================
// write data fifo with registered read data
module wdata_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] pop_data,
	output logic                  full,
	output logic                  empty
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;

	wire do_push = push && !full;
	wire do_pop  = pop && !empty;

	assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty = (wr_ptr_r == rd_ptr_r);

	always_ff @(posedge pclk) begin
		if (do_push)
			mem[wr_ptr_r[AW-1:0]] <= push_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			pop_data <= '0;
		end else begin
			if (do_push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
				pop_data <= mem[rd_ptr_r[AW-1:0]];
			end
		end
	end
endmodule // wdata_fifo

// ### hdl/bank_timers.sv
`timescale 1ns/1ps

// =====================================================================
// one row cycle countdown per bank, plus the data bus spacing timer
module bank_timers #(
	parameter int BANKS     = 8,
	parameter int RC_CYCLES = 2,
	parameter int DQ_CYCLES = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             issue,
	input  wire logic [2:0]       issue_bank,
	input  wire logic             issue_data,
	output logic      [BANKS-1:0] bank_ready,
	output logic                  dq_ready
);
	logic [7:0] cnt_r [BANKS];
	logic [7:0] dq_cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < BANKS; i++)
				cnt_r[i] <= 8'h00;
		end else begin
			for (int i = 0; i < BANKS; i++) begin
				if (issue && issue_bank == 3'(i))
					cnt_r[i] <= 8'(RC_CYCLES - 1);
				else if (cnt_r[i] != 8'h00)
					cnt_r[i] <= cnt_r[i] - 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dq_cnt_r <= 8'h00;
		else if (issue_data)
			dq_cnt_r <= 8'(DQ_CYCLES - 1);
		else if (dq_cnt_r != 8'h00)
			dq_cnt_r <= dq_cnt_r - 8'h01;
	end

	always_comb begin
		for (int i = 0; i < BANKS; i++)
			bank_ready[i] = (cnt_r[i] == 8'h00);
	end
	assign dq_ready = (dq_cnt_r == 8'h00);
endmodule // bank_timers

// ### verification/phy_model.sv
`timescale 1ns/1ps

// =====================================================================
// far side: calibration result and a small word memory behind the phy
module phy_model (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    fail_mode,
	input  wire logic                    corrupt,
	input  wire logic                    slow,
	input  wire dram_ctrl_pkg::phy_cmd_s phy_cmd,
	input  wire logic [17:0]             phy_wdata,
	input  wire logic                    phy_wdata_valid,
	output logic                         cal_success,
	output logic                         cal_fail,
	output logic                         phy_wdata_req,
	output logic                         phy_rdata_valid,
	output logic [17:0]                  phy_rdata
);
	logic [17:0] mem [logic [24:0]];
	logic [24:0] wr_addr_r;
	logic [24:0] rd_addr_r;
	logic [3:0]  cal_cnt_r;
	logic [2:0]  rd_dly_r;
	wire  [24:0] cmd_addr = {phy_cmd.row, phy_cmd.col, phy_cmd.bank};

	// calibration keeps the interface for a while after every reset
	assign cal_success = (cal_cnt_r == 4'hF) && !fail_mode;
	assign cal_fail    = (cal_cnt_r == 4'hF) && fail_mode;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_cnt_r <= 4'h0;
			rd_dly_r = 3'h0;
			phy_wdata_req <= 1'b0;
			phy_rdata_valid <= 1'b0;
			phy_rdata <= 18'h2AAAA;
		end else begin
			if (cal_cnt_r != 4'hF)
				cal_cnt_r <= cal_cnt_r + 4'h1;
			phy_wdata_req <= (phy_cmd.cmd == dram_ctrl_pkg::CMD_WRITE);
			if (phy_cmd.cmd == dram_ctrl_pkg::CMD_WRITE)
				wr_addr_r = cmd_addr;
			if (phy_wdata_valid)
				mem[wr_addr_r] = phy_wdata;
			phy_rdata_valid <= (rd_dly_r == 3'h1);
			// idle read bus inverts its last word every cycle; corruption hits only the low parity bit
			phy_rdata <= (rd_dly_r == 3'h1) ? (mem[rd_addr_r] ^ {9'h000, corrupt, 8'h00}) : ~phy_rdata;
			if (phy_cmd.cmd == dram_ctrl_pkg::CMD_READ) begin
				rd_addr_r = cmd_addr;
				rd_dly_r = slow ? 3'h4 : 3'h1;
			end else if (rd_dly_r != 3'h0)
				rd_dly_r = rd_dly_r - 3'h1;
		end
	end
endmodule // phy_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "dram_ctrl_regs.svh"

module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, user_read_req = 0, user_write_req = 0;
	logic [24:0] user_addr = 25'h0;
	logic [7:0] user_size = 8'h01;
	logic [15:0] user_wdata = 16'h0, user_rdata;
	logic user_ready, user_rdata_valid, parity_error, cal_success, cal_fail;
	logic phy_wdata_req, phy_rdata_valid, phy_wdata_valid;
	logic fail_mode = 0, corrupt = 0, slow = 0, cal_ok = 0;
	logic [17:0] phy_rdata, phy_wdata, wd_last;
	dram_ctrl_pkg::phy_cmd_s phy_cmd, last_rw;
	int err_total = 0, n_checks = 0, ref_cnt = 0, cyc = 0, last_cyc = -9, rd_cnt = 0;
	logic [31:0] rd;
	logic se;

	always #5 pclk = ~pclk;

	dram_ctrl #(.REFRESH_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.user_read_req(user_read_req), .user_write_req(user_write_req), .user_addr(user_addr),
		.user_size(user_size), .user_wdata(user_wdata), .user_ready(user_ready), .user_rdata_valid(user_rdata_valid),
		.user_rdata(user_rdata), .parity_error(parity_error), .cal_success(cal_success), .cal_fail(cal_fail),
		.phy_wdata_req(phy_wdata_req), .phy_rdata_valid(phy_rdata_valid), .phy_rdata(phy_rdata),
		.phy_cmd(phy_cmd), .phy_wdata(phy_wdata), .phy_wdata_valid(phy_wdata_valid));

	phy_model far (.pclk(pclk), .presetn(presetn), .fail_mode(fail_mode), .corrupt(corrupt), .slow(slow),
		.phy_cmd(phy_cmd), .phy_wdata(phy_wdata), .phy_wdata_valid(phy_wdata_valid),
		.cal_success(cal_success), .cal_fail(cal_fail), .phy_wdata_req(phy_wdata_req),
		.phy_rdata_valid(phy_rdata_valid), .phy_rdata(phy_rdata));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// =====================================================================
	// command monitor
	always @(posedge pclk) begin
		cyc++;
		cal_ok <= presetn && (cal_ok || cal_success);
		if (phy_wdata_valid)
			wd_last <= phy_wdata;
		if (phy_cmd.cmd !== dram_ctrl_pkg::CMD_NOP) begin
			chk("command before calibration", 1, cal_ok);
			if (phy_cmd.cmd === dram_ctrl_pkg::CMD_REFRESH)
				ref_cnt++;
			else begin
				chk("read write spacing", 1, (cyc - last_cyc) >= 2);
				if (phy_cmd.cmd === dram_ctrl_pkg::CMD_READ)
					rd_cnt++;
				last_cyc = cyc;
				last_rw <= phy_cmd;
			end
		end
	end

	// =====================================================================
	// bus tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("pready wait", 1, n);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic user_req(input logic w, input logic [24:0] a, input logic [15:0] d, input int lim, output logic ok);
		int n;
		@(posedge pclk);
		user_write_req <= w;
		user_read_req <= !w;
		user_addr <= a;
		user_wdata <= d;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (user_ready !== 1'b1 && n < lim);
		ok = user_ready;
		user_write_req <= 0;
		user_read_req <= 0;
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// =====================================================================
	// scenarios
	task automatic t_reset_state;
		apb(0, `CTRL_ADDR, 0);
		chk("ctrl reset", 32'h0, rd);
		apb(0, `STATUS_ADDR, 0);
		chk("fsm in init", dram_ctrl_pkg::ST_INIT, rd[1:0]);
		chk("ready in init", 0, user_ready);
		apb(0, 12'h010, 0);
		chk("unmapped error", 1, se);
		chk("unmapped data", 0, rd);
	endtask

	task automatic t_cal_pass;
		wait_cycles(20);
		apb(0, `STATUS_ADDR, 0);
		chk("fsm init done", dram_ctrl_pkg::ST_INIT_DONE, rd[1:0]);
		chk("all banks ready", 8'hFF, rd[15:8]);
	endtask

	task automatic t_write_read(input logic [24:0] a, input logic [15:0] d, input logic sl);
		logic ok;
		int n;
		apb(1, `CTRL_ADDR, 32'h2);
		slow <= sl;
		user_req(1, a, d, 50, ok);
		wait_cycles(8);
		chk("write cmd", dram_ctrl_pkg::CMD_WRITE, last_rw.cmd);
		chk("bank field", a[2:0], last_rw.bank);
		chk("col field", a[8:3], last_rw.col);
		chk("row field", a[24:9], last_rw.row);
		chk("parity word", {^d[15:8], d[15:8], ^d[7:0], d[7:0]}, wd_last);
		for (int k = 0; k < 2; k++) begin
			corrupt <= k[0];
			user_req(0, a, 0, 50, ok);
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (user_rdata_valid !== 1'b1 && n < 40);
			chk("read data", d, user_rdata);
			chk("parity flag", k, parity_error);
		end
		corrupt <= 0;
		apb(0, `STATUS_ADDR, 0);
		chk("sticky parity", 1, rd[`STATUS_PARITY_ERR_BIT]);
		apb(1, `STATUS_ADDR, 32'h00010000);
		apb(0, `STATUS_ADDR, 0);
		chk("sticky cleared", 0, rd[`STATUS_PARITY_ERR_BIT]);
	endtask

	// two-beat read: divider makes two issues, the second merges into the first burst
	task automatic t_burst;
		logic ok;
		int n0;
		n0 = rd_cnt;
		user_size <= 8'h02;
		user_req(0, 25'h0ABCD5, 0, 50, ok);
		user_size <= 8'h01;
		wait_cycles(12);
		chk("burst accepted", 1, ok);
		chk("reads for merged burst", 1, rd_cnt - n0);
	endtask

	task automatic t_refresh;
		apb(1, `CTRL_ADDR, 32'h0);
		ref_cnt = 0;
		wait_cycles(60);
		chk("auto refresh count", 1, ref_cnt >= 2 && ref_cnt <= 4);
		apb(1, `CTRL_ADDR, 32'h1);
		wait_cycles(5);
		ref_cnt = 0;
		wait_cycles(60);
		chk("no auto refresh", 0, ref_cnt);
		apb(1, `REFRESH_REQ_ADDR, 32'h1);
		wait_cycles(20);
		chk("user refresh", 1, ref_cnt);
	endtask

	task automatic t_cal_fail;
		logic ok;
		presetn <= 0;
		fail_mode <= 1;
		wait_cycles(2);
		presetn <= 1;
		wait_cycles(25);
		apb(0, `STATUS_ADDR, 0);
		chk("fsm init fail", dram_ctrl_pkg::ST_INIT_FAIL, rd[1:0]);
		user_req(0, 25'h10, 0, 30, ok);
		chk("refused after fail", 0, ok);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// generous: the whole sequence needs well under two thousand cycles
	initial begin
		#200us;
		err_total++;
		give_verdict();
	end

	initial begin
		wait_cycles(2);
		presetn <= 1;
		t_reset_state();
		t_cal_pass();
		t_write_read(25'h0ABCD5, 16'hA53C, 0);
		t_write_read(25'h1F0E32, 16'h0170, 1);
		t_refresh();
		t_burst();
		t_cal_fail();
		give_verdict();
	end
endmodule // testbench
